// >>> design/cfd_params.svh
// Purpose: constants of the can fd diagnostics and acceptance filter block
// Assumes: 16-bit register words, word addressed
// Notes:   offsets are word addresses on the plain register port
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH

`define CFD_ADDR_W          8
`define CFD_DATA_W          16
`define CFD_OFS_DIAG        8'h00
`define CFD_OFS_COUNT       8'h01
`define CFD_OFS_CONFIG      8'h02
`define CFD_OFS_FLTCON      8'h10
`define CFD_OFS_OBJ_HI      8'h20
`define CFD_OFS_OBJ_LO      8'h30
`define CFD_OFS_MASK_HI     8'h40
`define CFD_OFS_MASK_LO     8'h50

`define CFD_DIAG_WMASK      16'hfbbf
`define CFD_FLTCON_WMASK    16'h9f9f
`define CFD_HI_WMASK        16'h7fff
`define CFD_RESET_WORD      16'h0000

`define CFD_BIT_LEN_MM      15
`define CFD_BIT_ESI         14
`define CFD_BIT_D_CRC       13
`define CFD_BIT_D_STUFF     12
`define CFD_BIT_D_FORM      11
`define CFD_BIT_D_REC       9
`define CFD_BIT_D_DOM       8
`define CFD_BIT_BUS_OFF     7
`define CFD_BIT_N_CRC       5
`define CFD_BIT_N_STUFF     4
`define CFD_BIT_N_FORM      3
`define CFD_BIT_N_ACK       2
`define CFD_BIT_N_REC       1
`define CFD_BIT_N_DOM       0

`define CFD_FLT_EN_BIT      7
`define CFD_FILTER_EXTENDED_SELECT_BIT       14
`define CFD_MASK_TYPE_MATCH_ENABLE_BIT        14
`define CFD_NUM_FILTERS     16
`define CFD_STUFF_LIMIT     3'd5
`define CFD_RECOV_BITS      4'd11
`define CFD_CRC_W           21

`endif

// >>> design/cfd_pkg.sv
// Purpose: types of the can fd diagnostics and acceptance filter block
// Assumes: constants come from cfd_params.svh
// Notes:   identifier vector is {filter_std_ident_extra_bit, eid17..0, sid10..0}
package cfd_pkg;
    typedef logic [15:0] cfd_word_type;
    typedef logic [29:0] cfd_ident_type;
    typedef logic [4:0]  cfd_pointer_type;
    typedef enum logic [1:0] {
        CFD_PHASE_NOMINAL = 2'b01,
        CFD_PHASE_DATA    = 2'b10
    } cfd_phase_type;
endpackage : cfd_pkg

// >>> design/cfd_diag_filter.sv
// Purpose: bus error diagnostics, clean message counter and 16 acceptance filters
// Assumes: frame engine supplies sampled bits and frame events synchronous to clk
// Notes:   match result is registered, one cycle after match_req
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`include "cfd_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] flag length mismatch when the frame length code exceeds the element payload size
// [RULE2] flag a received fd frame whose error state indicator is set
// [RULE3] crc, stuff, form and bit errors in the data phase use separate flags
// [RULE4] flag bus-off entry once the node has recovered on its own
// [RULE5] flag nominal crc fault when computed and received checksums differ
// [RULE6] flag stuff fault on more than five equal bits inside the stuffed region
// [RULE7] flag form fault when a fixed-format bit has the wrong value
// [RULE8] flag acknowledge fault when our frame sees no dominant ack
// [RULE9] flag recessive fault: sent recessive, saw dominant, outside arbitration
// [RULE10] flag dominant fault: sent dominant, saw recessive
// [RULE11] during bus-off recovery set the dominant fault on every eleven recessive bits
// [RULE12] sixteen-bit clean message counter, writable by software, zero after reset
// [RULE13] a disabled filter never accepts; an enabled one joins matching
// [RULE14] control words hold two filters each: low byte even, high byte odd
// [RULE15] a matched frame goes to the object named by the filter pointer
// [RULE16] software never programs pointer zero
// [RULE17] software never programs pointers 24 to 31
// [RULE18] with type match on, extended select picks extended or standard frames only
// [RULE19] object high word: extended select 14, filter_std_ident_extra_bit 13, eid17..5 at 12..0
// [RULE20] legacy byte mode compares upper eid filter bits with first two data bytes
// [RULE21] with type match off, both frame kinds pass when masked bits agree
// [RULE22] only bits selected by the mask take part in comparison
module cfd_diag_filter
    import cfd_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [`CFD_ADDR_W-1:0]   reg_addr,
    input  wire logic [`CFD_DATA_W-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [`CFD_DATA_W-1:0]   reg_rdata,
    input  wire logic                     bit_strobe,
    input  wire logic                     bus_level,
    input  wire logic                     tx_level,
    input  wire logic                     tx_active,
    input  wire logic                     in_arbitration,
    input  wire logic                     data_phase,
    input  wire logic                     stuff_region,
    input  wire logic                     form_check,
    input  wire logic                     form_expected,
    input  wire logic                     ack_slot,
    input  wire logic                     crc_check,
    input  wire logic [`CFD_CRC_W-1:0]    crc_calc,
    input  wire logic [`CFD_CRC_W-1:0]    crc_rx,
    input  wire logic                     len_check,
    input  wire logic [3:0]               frame_dlc,
    input  wire logic [2:0]               fifo_payload_size,
    input  wire logic                     rx_fd_done,
    input  wire logic                     rx_esi,
    input  wire logic                     bus_off,
    input  wire logic                     msg_ok,
    input  wire logic                     match_req,
    input  wire logic                     frame_ide,
    input  wire logic [10:0]              frame_sid,
    input  wire logic                     frame_filter_std_ident_extra_bit,
    input  wire logic [17:0]              frame_eid,
    input  wire logic [7:0]               frame_data0,
    input  wire logic [7:0]               frame_data1,
    output logic                          match_valid,
    output logic                          match_hit,
    output logic      [4:0]               match_object,
    output logic      [3:0]               match_filter,
    output logic      [15:0]              diag_flags
);

    cfd_word_type  diag;
    cfd_word_type  clean_count;
    logic          byte_filter_mode;
    cfd_word_type  fltcon   [0:7];
    cfd_word_type  obj_hi   [0:15];
    cfd_word_type  obj_lo   [0:15];
    cfd_word_type  mask_hi  [0:15];
    cfd_word_type  mask_lo  [0:15];

    function automatic logic filt_enable(input logic [3:0] n, input cfd_word_type w);
        filt_enable = n[0] ? w[`CFD_FLT_EN_BIT+8] : w[`CFD_FLT_EN_BIT]; // [RULE14]
    endfunction : filt_enable

    function automatic cfd_pointer_type filt_ptr(input logic [3:0] n, input cfd_word_type w);
        filt_ptr = n[0] ? w[12:8] : w[4:0]; // [RULE14]
    endfunction : filt_ptr

    // ---------------- register port
    wire sel_diag   = reg_addr == `CFD_OFS_DIAG;
    wire sel_count  = reg_addr == `CFD_OFS_COUNT;
    wire sel_config = reg_addr == `CFD_OFS_CONFIG;
    wire sel_fltcon = reg_addr[7:3] == 5'(`CFD_OFS_FLTCON >> 3);
    wire sel_obj_hi = reg_addr[7:4] == 4'(`CFD_OFS_OBJ_HI >> 4);
    wire sel_obj_lo = reg_addr[7:4] == 4'(`CFD_OFS_OBJ_LO >> 4);
    wire sel_msk_hi = reg_addr[7:4] == 4'(`CFD_OFS_MASK_HI >> 4);
    wire sel_msk_lo = reg_addr[7:4] == 4'(`CFD_OFS_MASK_LO >> 4);
    wire [3:0] idx  = reg_addr[3:0];

    // ---------------- bit level error detection
    logic       last_level;
    logic [2:0] run_len;
    logic [3:0] rec_run;
    logic       bus_off_d;

    wire same_level   = bus_level == last_level;
    wire stuff_fault  = bit_strobe & stuff_region & same_level
                        & (run_len == `CFD_STUFF_LIMIT); // [RULE6]
    wire form_fault   = bit_strobe & form_check & (bus_level != form_expected); // [RULE7]
    wire rec_fault    = bit_strobe & tx_active & ~in_arbitration
                        & tx_level & ~bus_level; // [RULE9]
    wire dom_fault    = bit_strobe & tx_active & ~tx_level & bus_level; // [RULE10]
    wire ack_fault    = bit_strobe & tx_active & ack_slot & bus_level; // [RULE8]
    wire crc_fault    = crc_check & (crc_calc != crc_rx); // [RULE5]
    wire recov_tick   = bit_strobe & bus_off & bus_level
                        & (rec_run == `CFD_RECOV_BITS - 4'd1); // [RULE11]
    wire bus_off_done = bus_off_d & ~bus_off; // [RULE4]
    wire len_fault    = len_check & (frame_dlc > {1'b1, fifo_payload_size}); // [RULE1]
    wire esi_seen     = rx_fd_done & rx_esi; // [RULE2]

    cfd_phase_type phase;
    assign phase = data_phase ? CFD_PHASE_DATA : CFD_PHASE_NOMINAL;

    cfd_word_type set_vec;
    always_comb begin
        set_vec = `CFD_RESET_WORD;
        set_vec[`CFD_BIT_LEN_MM]  = len_fault;
        set_vec[`CFD_BIT_ESI]     = esi_seen;
        set_vec[`CFD_BIT_BUS_OFF] = bus_off_done;
        set_vec[`CFD_BIT_N_ACK]   = ack_fault;
        unique case (phase)
            CFD_PHASE_DATA: begin // [RULE3]
                set_vec[`CFD_BIT_D_CRC]   = crc_fault;
                set_vec[`CFD_BIT_D_STUFF] = stuff_fault;
                set_vec[`CFD_BIT_D_FORM]  = form_fault;
                set_vec[`CFD_BIT_D_REC]   = rec_fault;
                set_vec[`CFD_BIT_D_DOM]   = dom_fault;
                set_vec[`CFD_BIT_N_DOM]   = recov_tick;
            end
            CFD_PHASE_NOMINAL: begin
                set_vec[`CFD_BIT_N_CRC]   = crc_fault;
                set_vec[`CFD_BIT_N_STUFF] = stuff_fault;
                set_vec[`CFD_BIT_N_FORM]  = form_fault;
                set_vec[`CFD_BIT_N_REC]   = rec_fault;
                set_vec[`CFD_BIT_N_DOM]   = dom_fault | recov_tick;
            end
        endcase
    end

    // software may clear the data crc flag but never set it; events win over clears
    wire  diag_wr = reg_wr & sel_diag;
    cfd_word_type wr_diag;
    assign wr_diag = (reg_wdata & `CFD_DIAG_WMASK & ~(16'h0001 << `CFD_BIT_D_CRC))
                   | (reg_wdata & diag & (16'h0001 << `CFD_BIT_D_CRC));
    cfd_word_type next_diag;
    assign next_diag = (diag_wr ? wr_diag : diag) | set_vec;

    cfd_word_type next_count;
    assign next_count = (reg_wr & sel_count ? reg_wdata : clean_count)
                      + {15'h0000, msg_ok}; // [RULE12]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            diag        <= `CFD_RESET_WORD;
            clean_count <= `CFD_RESET_WORD;
            last_level  <= 1'b1;
            run_len     <= 3'd0;
            rec_run     <= 4'd0;
            bus_off_d   <= 1'b0;
        end else begin
            diag        <= next_diag;
            clean_count <= next_count;
            bus_off_d   <= bus_off;
            if (bit_strobe) begin
                last_level <= bus_level;
                run_len    <= (stuff_region && same_level && run_len != 3'd7)
                              ? run_len + 3'd1 : 3'd1;
                rec_run    <= (bus_off && bus_level && !recov_tick)
                              ? rec_run + 4'd1 : 4'd0;
            end
        end
    end

    // ---------------- configuration storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            byte_filter_mode <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                fltcon[i] <= `CFD_RESET_WORD;
            end
            for (int i = 0; i < `CFD_NUM_FILTERS; i++) begin
                obj_hi[i]  <= `CFD_RESET_WORD;
                obj_lo[i]  <= `CFD_RESET_WORD;
                mask_hi[i] <= `CFD_RESET_WORD;
                mask_lo[i] <= `CFD_RESET_WORD;
            end
        end else if (reg_wr) begin
            if (sel_config) byte_filter_mode <= reg_wdata[0];
            if (sel_fltcon) fltcon[idx[2:0]] <= reg_wdata & `CFD_FLTCON_WMASK;
            if (sel_obj_hi) obj_hi[idx]  <= reg_wdata & `CFD_HI_WMASK; // [RULE19]
            if (sel_obj_lo) obj_lo[idx]  <= reg_wdata;
            if (sel_msk_hi) mask_hi[idx] <= reg_wdata & `CFD_HI_WMASK;
            if (sel_msk_lo) mask_lo[idx] <= reg_wdata;
        end
    end

    cfd_word_type rd_mux;
    assign rd_mux = sel_diag   ? diag
                  : sel_count  ? clean_count
                  : sel_config ? {15'h0000, byte_filter_mode}
                  : sel_fltcon ? fltcon[idx[2:0]]
                  : sel_obj_hi ? obj_hi[idx]
                  : sel_obj_lo ? obj_lo[idx]
                  : sel_msk_hi ? mask_hi[idx]
                  : sel_msk_lo ? mask_lo[idx]
                  : `CFD_RESET_WORD;

    always_ff @(posedge clk) begin
        if (!rst_n) reg_rdata <= `CFD_RESET_WORD;
        else        reg_rdata <= reg_rd ? rd_mux : `CFD_RESET_WORD;
    end

    assign diag_flags = diag;

    // ---------------- acceptance filtering
    cfd_ident_type msg_vec;
    logic [17:0]   msg_eid;
    assign msg_eid = byte_filter_mode
                   ? {frame_data0, frame_data1, frame_eid[1:0]} // [RULE20]
                   : frame_eid;
    assign msg_vec = {frame_filter_std_ident_extra_bit, msg_eid, frame_sid};

    logic [`CFD_NUM_FILTERS-1:0] hit_vec;
    logic [`CFD_NUM_FILTERS-1:0] en_vec;
    genvar g;
    generate
        for (g = 0; g < `CFD_NUM_FILTERS; g++) begin : g_filter
            cfd_ident_type filt_vec;
            cfd_ident_type mask_vec;
            logic          type_ok;
            logic          ident_ok;
            assign filt_vec = {obj_hi[g][13:0], obj_lo[g][15:11], obj_lo[g][10:0]};
            assign mask_vec = {mask_hi[g][13:0], mask_lo[g][15:11], mask_lo[g][10:0]};
            assign ident_ok = ((filt_vec ^ msg_vec) & mask_vec) == 30'h00000000; // [RULE22]
            assign type_ok  = mask_hi[g][`CFD_MASK_TYPE_MATCH_ENABLE_BIT]
                            ? (obj_hi[g][`CFD_FILTER_EXTENDED_SELECT_BIT] == frame_ide) // [RULE18]
                            : 1'b1; // [RULE21]
            assign en_vec[g]  = filt_enable(4'(g), fltcon[g/2]);
            assign hit_vec[g] = en_vec[g] & type_ok & ident_ok; // [RULE13]
        end
    endgenerate

    logic [3:0] first_hit;
    always_comb begin
        first_hit = 4'h0;
        for (int i = `CFD_NUM_FILTERS - 1; i >= 0; i--) begin
            if (hit_vec[i]) first_hit = 4'(i);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_valid  <= 1'b0;
            match_hit    <= 1'b0;
            match_object <= 5'h00;
            match_filter <= 4'h0;
        end else begin
            match_valid  <= match_req;
            match_hit    <= match_req & (|hit_vec);
            match_object <= filt_ptr(first_hit, fltcon[first_hit[3:1]]); // [RULE15]
            match_filter <= first_hit;
        end
    end

    // ---------------- assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_recessive_run;
        (bit_strobe && bus_off && bus_level && rec_run == 4'd10);
    endsequence

    a_len_mismatch_set: assert property ( // [RULE1]
        len_check && frame_dlc > {1'b1, fifo_payload_size} |=> diag[`CFD_BIT_LEN_MM])
        else $error("length mismatch not flagged");
    a_esi_flag_set: assert property ( // [RULE2]
        rx_fd_done && rx_esi |=> diag[`CFD_BIT_ESI])
        else $error("esi flag not set");
    a_data_crc_split: assert property ( // [RULE3]
        crc_check && data_phase && crc_calc != crc_rx && !diag[`CFD_BIT_N_CRC]
        |=> diag[`CFD_BIT_D_CRC] && !diag[`CFD_BIT_N_CRC])
        else $error("data phase crc fault misrouted");
    a_bus_off_event: assert property ( // [RULE4]
        $fell(bus_off) |=> diag[`CFD_BIT_BUS_OFF])
        else $error("bus off recovery not flagged");
    a_stuff_sixth_bit: assert property ( // [RULE6]
        bit_strobe && stuff_region && !data_phase && same_level && run_len == 3'd5
        |=> diag[`CFD_BIT_N_STUFF])
        else $error("stuff fault missed");
    a_rec_fault_set: assert property ( // [RULE9]
        bit_strobe && tx_active && !in_arbitration && tx_level && !bus_level && !data_phase
        |=> diag[`CFD_BIT_N_REC])
        else $error("recessive fault missed");
    a_recovery_tick: assert property ( // [RULE11]
        (s_recessive_run and !data_phase) |=> diag[`CFD_BIT_N_DOM] && rec_run == 4'd0)
        else $error("recovery progress not flagged");
    a_count_step: assert property ( // [RULE12]
        msg_ok && !(reg_wr && sel_count) |=> clean_count == $past(clean_count) + 16'h0001)
        else $error("clean counter did not step");
    a_disabled_never: assert property ( // [RULE13]
        match_req && en_vec == 16'h0000 |=> match_valid && !match_hit)
        else $error("disabled filter accepted a frame");
    a_object_pointer: assert property ( // [RULE15]
        match_req && hit_vec[0] |=> match_hit && match_filter == 4'h0
        && match_object == $past(fltcon[0][4:0]))
        else $error("wrong object pointer");

endmodule : cfd_diag_filter

`default_nettype wire

// >>> verif/cfd_bus_node.sv
// Purpose: far nodes on the can fd bus as seen through the transceiver
// Assumes: 1 is recessive, the bus is a wired-and of all drivers
// Notes:   stuck_rec models a broken line that a dominant bit cannot pull low
`timescale 1ns/1ps
`default_nettype none
module cfd_bus_node (
    input  wire logic tx_level,
    input  wire logic ack_slot,
    input  wire logic give_ack,
    input  wire logic drive_dom,
    input  wire logic stuck_rec,
    output logic      bus_level
);
    // another node answers the ack slot or forces a dominant bit
    wire logic other_dom = drive_dom | (ack_slot & give_ack);
    assign bus_level = stuck_rec | (tx_level & ~other_dom);
endmodule : cfd_bus_node
`default_nettype wire

// >>> verif/can_fd_diag_and_accept_filter_bench.sv
// Purpose: self-checking bench for the diagnostics and acceptance filter block
// Assumes: bit faults are taken on bit_strobe, flags clear by writing zero
// Notes:   far nodes come from cfd_bus_node
`timescale 1ns/1ps
`default_nettype none
module can_fd_diag_and_accept_filter_bench
    import cfd_pkg::*;
;
    logic         clk, rst_n, reg_wr, reg_rd, match_valid, match_hit, bus_level;
    logic [7:0]   reg_addr, frame_data0, frame_data1;
    cfd_word_type reg_wdata, reg_rdata, diag_flags;
    logic         bit_strobe, msg_ok, rx_fd_done, len_check, crc_check;
    logic         tx_level, tx_active, in_arbitration, data_phase, stuff_region;
    logic         form_check, form_expected, ack_slot, rx_esi, bus_off, match_req;
    logic         frame_ide, frame_filter_std_ident_extra_bit, give_ack, drive_dom, stuck_rec;
    logic [20:0]  crc_calc, crc_rx;
    logic [3:0]   frame_dlc, match_filter;
    logic [2:0]   fifo_payload_size;
    logic [10:0]  frame_sid;
    logic [17:0]  frame_eid;
    logic [4:0]   match_object, pulses;
    int           n_fail, checks;

    assign {bit_strobe, msg_ok, rx_fd_done, len_check, crc_check} = pulses;

    cfd_bus_node u_bus (.tx_level, .ack_slot, .give_ack, .drive_dom, .stuck_rec, .bus_level);
    cfd_diag_filter u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .bit_strobe, .bus_level, .tx_level, .tx_active, .in_arbitration, .data_phase,
        .stuff_region, .form_check, .form_expected, .ack_slot, .crc_check, .crc_calc,
        .crc_rx, .len_check, .frame_dlc, .fifo_payload_size, .rx_fd_done, .rx_esi,
        .bus_off, .msg_ok, .match_req, .frame_ide, .frame_sid, .frame_filter_std_ident_extra_bit, .frame_eid,
        .frame_data0, .frame_data1, .match_valid, .match_hit, .match_object,
        .match_filter, .diag_flags);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run;
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic check(input string name, input cfd_word_type e, input cfd_word_type g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input cfd_word_type d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input cfd_word_type e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg_%h", a), e, reg_rdata);
    endtask : reg_read

    // strobe one event input for n consecutive cycles
    task automatic pulse(input int i, input int n);
        @(posedge clk);
        pulses[i] <= 1'b1;
        repeat (n) @(posedge clk);
        pulses[i] <= 1'b0;
    endtask : pulse

    task automatic diag_is(input cfd_word_type e);
        reg_read(8'h00, e);
        check("diag_flags", e, diag_flags);
        reg_write(8'h00, 16'h0000);
    endtask : diag_is

    task automatic test_regs;
        logic [7:0]  a [6] = '{8'h00, 8'h01, 8'h10, 8'h20, 8'h40, 8'h7f};
        logic [39:0] w [4] = '{{8'h17, 16'hffff, 16'h9f9f}, {8'h2f, 16'hffff, 16'h7fff},
                               {8'h00, 16'hffff, 16'hdbbf}, {8'h7f, 16'hffff, 16'h0000}};
        foreach (a[i]) reg_read(a[i], 16'h0000);
        foreach (w[i]) begin
            reg_write(w[i][39:32], w[i][31:16]);
            reg_read(w[i][39:32], w[i][15:0]);
            reg_write(w[i][39:32], 16'h0000);
        end
    endtask : test_regs

    task automatic test_counter;
        reg_write(8'h01, 16'hfffe);
        pulse(3, 2);
        reg_read(8'h01, 16'h0000);
        pulse(3, 1);
        reg_read(8'h01, 16'h0001);
    endtask : test_counter

    task automatic test_events;
        logic [6:0] lt [3] = '{{4'd9, 3'd1}, {4'd15, 3'd7}, {4'd8, 3'd0}};
        foreach (lt[i]) begin
            {frame_dlc, fifo_payload_size} <= lt[i];
            pulse(1, 1);
            diag_is(16'h0000);
        end
        {frame_dlc, fifo_payload_size} <= {4'd9, 3'd0};
        pulse(1, 1);
        diag_is(16'h8000);
        pulse(2, 1);
        diag_is(16'h0000);
        rx_esi <= 1'b1;
        pulse(2, 1);
        diag_is(16'h4000);
        bus_off <= 1'b1;
        pulse(4, 10);
        diag_is(16'h0000);
        pulse(4, 1);
        diag_is(16'h0001);
        bus_off <= 1'b0;
        repeat (2) @(posedge clk);
        diag_is(16'h0080);
    endtask : test_events

    task automatic test_diag;
        for (int p = 0; p < 2; p++) begin
            data_phase <= p[0];
            {crc_calc, crc_rx} <= {21'h1, 21'h1};
            pulse(0, 1);
            diag_is(16'h0000);
            crc_rx <= 21'h2;
            pulse(0, 1);
            {stuff_region, drive_dom} <= 2'b10;
            diag_is(p ? 16'h2000 : 16'h0020);
            pulse(4, 1);
            drive_dom <= 1'b1;
            pulse(4, 5);
            diag_is(16'h0000);
            pulse(4, 1);
            {stuff_region, drive_dom, form_check, form_expected} <= 4'b0011;
            diag_is(p ? 16'h1000 : 16'h0010);
            pulse(4, 1);
            diag_is(16'h0000);
            form_expected <= 1'b0;
            pulse(4, 1);
            {form_check, tx_active, drive_dom, in_arbitration} <= 4'b0111;
            diag_is(p ? 16'h0800 : 16'h0008);
            pulse(4, 1);
            diag_is(16'h0000);
            in_arbitration <= 1'b0;
            pulse(4, 1);
            {drive_dom, tx_level} <= 2'b00;
            diag_is(p ? 16'h0200 : 16'h0002);
            pulse(4, 1);
            diag_is(16'h0000);
            stuck_rec <= 1'b1;
            pulse(4, 1);
            {stuck_rec, tx_level} <= 2'b01;
            diag_is(p ? 16'h0100 : 16'h0001);
            {ack_slot, give_ack} <= 2'b10;
            pulse(4, 1);
            {ack_slot, give_ack, tx_active} <= 3'b010;
            diag_is(16'h0004);
        end
        data_phase <= 1'b0;
    endtask : test_diag

    task automatic m(input logic ide, input logic [10:0] sid, input logic [17:0] filter_extended_ident_bits,
                     input cfd_word_type dd, input logic hit, input logic [4:0] obj,
                     input logic [3:0] flt);
        @(posedge clk);
        {match_req, frame_ide, frame_sid, frame_eid} <= {1'b1, ide, sid, filter_extended_ident_bits};
        {frame_data0, frame_data1} <= dd;
        @(posedge clk);
        match_req <= 1'b0;
        #1;
        check("match_valid", 16'h0001, {15'h0, match_valid});
        check("match_hit", {15'h0, hit}, {15'h0, match_hit});
        if (hit) begin
            check("match_object", {11'h0, obj}, {11'h0, match_object});
            check("match_filter", {12'h0, flt}, {12'h0, match_filter});
        end
    endtask : m

    task automatic test_match;
        reg_write(8'h11, 16'h0083);
        reg_write(8'h32, 16'h0123);
        reg_write(8'h52, 16'h07ff);
        m(1'b0, 11'h123, 18'h0, 16'h0, 1'b1, 5'd3, 4'd2);
        m(1'b0, 11'h124, 18'h0, 16'h0, 1'b0, 5'd0, 4'd0);
        m(1'b1, 11'h123, 18'h3ffff, 16'h0, 1'b1, 5'd3, 4'd2);
        reg_write(8'h42, 16'h4000);
        m(1'b1, 11'h123, 18'h0, 16'h0, 1'b0, 5'd0, 4'd0);
        m(1'b0, 11'h123, 18'h0, 16'h0, 1'b1, 5'd3, 4'd2);
        reg_write(8'h22, 16'h4000);
        m(1'b0, 11'h123, 18'h0, 16'h0, 1'b0, 5'd0, 4'd0);
        m(1'b1, 11'h123, 18'h0, 16'h0, 1'b1, 5'd3, 4'd2);
        reg_write(8'h11, 16'h0003);
        m(1'b1, 11'h123, 18'h0, 16'h0, 1'b0, 5'd0, 4'd0);
        reg_write(8'h25, 16'h0aaa);
        reg_write(8'h35, 16'h0055);
        reg_write(8'h45, 16'h1fff);
        reg_write(8'h55, 16'h07ff);
        for (int p = 1; p < 8; p++) begin
            reg_write(8'h12, 16'h8000 | 16'(p << 8));
            m(1'b0, 11'h055, 18'h15540, 16'h0, 1'b1, p[4:0], 4'd5);
        end
        m(1'b0, 11'h055, 18'h15560, 16'h0, 1'b0, 5'd0, 4'd0);
        reg_write(8'h02, 16'h0001);
        m(1'b0, 11'h055, 18'h0, 16'h5550, 1'b1, 5'd7, 4'd5);
        m(1'b0, 11'h055, 18'h0, 16'h5558, 1'b0, 5'd0, 4'd0);
        // filter 0 with an empty mask takes every frame and outranks filter 5
        reg_write(8'h10, 16'h0081);
        m(1'b0, 11'h055, 18'h0, 16'h5550, 1'b1, 5'd1, 4'd0);
    endtask : test_match

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, pulses} = '0;
        {tx_level, tx_active, in_arbitration, data_phase, stuff_region} = 5'b10000;
        {form_check, form_expected, ack_slot, give_ack, drive_dom, stuck_rec} = '0;
        {crc_calc, crc_rx, frame_dlc, fifo_payload_size, rx_esi, bus_off} = '0;
        {match_req, frame_ide, frame_sid, frame_filter_std_ident_extra_bit, frame_eid} = '0;
        {frame_data0, frame_data1} = '0;
        n_fail = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_counter();
        test_events();
        test_diag();
        test_match();
        complete_run();
    end
endmodule : can_fd_diag_and_accept_filter_bench
`default_nettype wire
